//--- hw/cold_load_inrush_guard.sv
// Cold-load guard: detects warm-to-cold load transitions and holds a
// desensitising enable through the following inrush, with an AXI4-Lite
// register slave and a level interrupt.
// Assumes breaker_position and ext_block are asynchronous pins; current
// comparator flags and auto_reclose_active come from logic on ref_clk.
//
// What this block does
// - Detect cold load by breaker open, undercurrent, both, or either.
// - Start the load-off delay when cold load is detected.
// - Raise the cold-load enable when the load-off delay expires.
// - Start inrush supervision when the cold condition ends.
// - Register inrush once current exceeds the inrush threshold.
// - Inrush ends once current falls to ninety percent of threshold.
// - After inrush, drop the enable when the settle timer or the max-block timer expires.
// - Max-block timer starts with supervision; expiry drops the enable.
// - Stop max-block timer when current stays below 0.9 threshold for settle time.
// - Suppress the whole function while the selected block input is set.
// - Block automatically while an auto-reclose sequence runs.
// - Produce only the enable indication, never a trip.
`timescale 1ns/100ps
`include "cold_load_params.svh"
module cold_load_inrush_guard #(
  parameter int ADDR_W = 8,
  parameter int TIMER_W = 16,
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter bit HAS_AUTO_RECLOSE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic breaker_position,
  input wire logic ext_block,
  input wire logic cold_load_undercurrent_flag,
  input wire logic inrush_above,
  input wire logic inrush_below_ninety,
  input wire logic auto_reclose_active,
  output logic cold_load_enable,
  output logic irq
);
  import cold_load_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Declarations
  // ****************************************
  logic [4:0] ctrl;
  logic [TIMER_W-1:0] t_loadoff;
  logic [TIMER_W-1:0] t_settle;
  logic [TIMER_W-1:0] t_maxblk;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] events;
  logic [3:0] clear_bits;
  logic [1:0] pins_level;
  logic breaker_closed;
  logic ext_block_level;
  logic [TICK_W-1:0] tick_count;
  logic tick;
  guard_state_t state;
  guard_state_t next_state;
  logic cold;
  logic blocked;
  logic loadoff_expired;
  logic settle_expired;
  logic maxblk_expired;
  logic loadoff_running;
  logic settle_running;
  logic maxblk_running;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  // ****************************************
  // Helpers
  // ****************************************
  // Enable is held in every state past the load-off delay
  function automatic logic state_on(input guard_state_t s);
    return (s == ST_COLD) || (s == ST_ARMED) || (s == ST_INRUSH) || (s == ST_SETTLE);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == `OFS_CTRL) || (a == `OFS_LOADOFF) || (a == `OFS_SETTLE) ||
           (a == `OFS_MAXBLK) || (a == `OFS_STATUS) || (a == `OFS_IRQ_STATUS) ||
           (a == `OFS_IRQ_CLEAR) || (a == `OFS_IRQ_ENABLE);
  endfunction

  // ****************************************
  // Inputs and timebase
  // ****************************************
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin({ext_block, breaker_position}),
    .level(pins_level)
  );
  assign breaker_closed = pins_level[0];
  assign ext_block_level = pins_level[1];

  // Free-running tick divider shared by all delay timers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else if (tick_count == TICK_W'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + TICK_W'(1);
      tick <= 1'b0;
    end
  end

  // ****************************************
  // Detection and blocking
  // ****************************************
  // Cold condition per the selected detection mode
  always_comb begin
    unique case (detect_mode_t'(ctrl[`CTRL_MODE_LSB +: 2]))
      DET_BREAKER: cold = !breaker_closed;
      DET_UNDER: cold = cold_load_undercurrent_flag;
      DET_AND: cold = !breaker_closed && cold_load_undercurrent_flag;
      DET_OR: cold = !breaker_closed || cold_load_undercurrent_flag;
    endcase
  end

  // Stopped function, selected external pin, software block or reclosing
  assign blocked = !ctrl[`CTRL_RUN_BIT] || ctrl[`CTRL_SW_BLOCK_BIT] ||
                   (ctrl[`CTRL_EXT_SEL_BIT] && ext_block_level) ||
                   (HAS_AUTO_RECLOSE && auto_reclose_active);

  // ****************************************
  // Sequence
  // ****************************************
  always_comb begin
    next_state = state;
    if (blocked) begin
      next_state = ST_WARM;
    end else begin
      unique case (state)
        ST_WARM: if (cold) next_state = ST_LOADOFF;
        ST_LOADOFF: begin
          if (!cold) next_state = ST_WARM;
          else if (loadoff_expired) next_state = ST_COLD;
        end
        ST_COLD: if (!cold) next_state = ST_ARMED;
        ST_ARMED: begin
          if (cold) next_state = ST_COLD;
          else if (maxblk_expired) next_state = ST_WARM;
          else if (inrush_above) next_state = ST_INRUSH;
          else if (inrush_below_ninety) next_state = ST_SETTLE;
        end
        ST_INRUSH: begin
          if (cold) next_state = ST_COLD;
          else if (maxblk_expired) next_state = ST_WARM;
          else if (inrush_below_ninety) next_state = ST_SETTLE;
        end
        ST_SETTLE: begin
          if (cold) next_state = ST_COLD;
          else if (settle_expired) next_state = ST_WARM;
          else if (maxblk_expired) next_state = ST_WARM;
          else if (inrush_above) next_state = ST_INRUSH;
          else if (!inrush_below_ninety) next_state = ST_INRUSH;
        end
        default: next_state = ST_WARM;
      endcase
    end
  end

  // The enable is a signal only; nothing here can trip
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_WARM;
      cold_load_enable <= 1'b0;
    end else begin
      state <= next_state;
      cold_load_enable <= state_on(next_state);
    end
  end

  // ****************************************
  // Delay timers
  // ****************************************
  tick_timer #(
    .WIDTH(TIMER_W)
  ) u_loadoff (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .start(state != ST_LOADOFF && next_state == ST_LOADOFF),
    .stop(next_state != ST_LOADOFF),
    .preset(t_loadoff),
    .running(loadoff_running),
    .expired(loadoff_expired)
  );

  // Max-block runs from the end of the cold condition to the drop of enable
  tick_timer #(
    .WIDTH(TIMER_W)
  ) u_maxblk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .start(state == ST_COLD && next_state == ST_ARMED),
    .stop(next_state == ST_WARM || next_state == ST_COLD),
    .preset(t_maxblk),
    .running(maxblk_running),
    .expired(maxblk_expired)
  );

  // Settle restarts on every fresh entry below ninety percent
  tick_timer #(
    .WIDTH(TIMER_W)
  ) u_settle (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .start(state != ST_SETTLE && next_state == ST_SETTLE),
    .stop(next_state != ST_SETTLE),
    .preset(t_settle),
    .running(settle_running),
    .expired(settle_expired)
  );

  // ****************************************
  // Interrupt status
  // ****************************************
  assign events[`EV_ENABLE_RISE] = !state_on(state) && state_on(next_state);
  assign events[`EV_ENABLE_FALL] = state_on(state) && !state_on(next_state);
  assign events[`EV_INRUSH] = state != ST_INRUSH && next_state == ST_INRUSH;
  assign events[`EV_MAXBLK] = maxblk_expired;
  assign clear_bits = (do_write && aw_addr == `OFS_IRQ_CLEAR && w_strb[0]) ? w_data[3:0] : 4'h0;

  // A set in the clearing cycle wins, so no event is lost
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clear_bits) | events;
      irq <= |(((irq_status & ~clear_bits) | events) & irq_enable);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address and data are taken in either order and held until both are in
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (mapped(aw_addr) && aw_addr != `OFS_STATUS &&
                        aw_addr != `OFS_IRQ_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; read-only words ignore writes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `CTRL_RESET;
      t_loadoff <= `LOADOFF_RESET;
      t_settle <= `SETTLE_RESET;
      t_maxblk <= `MAXBLK_RESET;
      irq_enable <= `IRQ_ENABLE_RESET;
    end else if (do_write) begin
      unique case (aw_addr)
        `OFS_CTRL: ctrl <= 5'(merge(32'(ctrl), w_data, w_strb));
        `OFS_LOADOFF: t_loadoff <= TIMER_W'(merge(32'(t_loadoff), w_data, w_strb));
        `OFS_SETTLE: t_settle <= TIMER_W'(merge(32'(t_settle), w_data, w_strb));
        `OFS_MAXBLK: t_maxblk <= TIMER_W'(merge(32'(t_maxblk), w_data, w_strb));
        `OFS_IRQ_ENABLE: irq_enable <= 4'(merge(32'(irq_enable), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  // One-cycle read latency; unmapped offsets answer zero with an error
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= {27'h0, ctrl};
        `OFS_LOADOFF: s_axi_rdata <= {16'h0, t_loadoff};
        `OFS_SETTLE: s_axi_rdata <= {16'h0, t_settle};
        `OFS_MAXBLK: s_axi_rdata <= {16'h0, t_maxblk};
        `OFS_STATUS: s_axi_rdata <= {20'h0, loadoff_running, settle_running, maxblk_running,
                                     blocked, cold_load_undercurrent_flag, breaker_closed,
                                     cold, cold_load_enable, 1'b0, state};
        `OFS_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
        `OFS_IRQ_ENABLE: s_axi_rdata <= {28'h0, irq_enable};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- hw/cold_load_params.svh
// Offsets, field positions, reset values and timing counts of the cold-load guard.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef COLD_LOAD_PARAMS_SVH
`define COLD_LOAD_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_LOADOFF 8'h04
`define OFS_SETTLE 8'h08
`define OFS_MAXBLK 8'h0c
`define OFS_STATUS 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_CLEAR 8'h18
`define OFS_IRQ_ENABLE 8'h1c

// ****************************************
// Field positions
// ****************************************
`define CTRL_MODE_LSB 0
`define CTRL_RUN_BIT 2
`define CTRL_EXT_SEL_BIT 3
`define CTRL_SW_BLOCK_BIT 4
`define EV_ENABLE_RISE 0
`define EV_ENABLE_FALL 1
`define EV_INRUSH 2
`define EV_MAXBLK 3

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET 5'h00
`define LOADOFF_RESET 16'h0064
`define SETTLE_RESET 16'h000a
`define MAXBLK_RESET 16'h03e8
`define IRQ_ENABLE_RESET 4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

//--- hw/cold_load_pkg.sv
// Types shared by the cold-load guard design files.
// Assumes compilation before any module that imports it.
package cold_load_pkg;

  // ****************************************
  // Detection modes and sequence states
  // ****************************************
  typedef enum logic [1:0] {
    DET_BREAKER = 2'b00,
    DET_UNDER = 2'b01,
    DET_AND = 2'b10,
    DET_OR = 2'b11
  } detect_mode_t;

  typedef enum logic [2:0] {
    ST_WARM = 3'b000,
    ST_LOADOFF = 3'b001,
    ST_COLD = 3'b010,
    ST_ARMED = 3'b011,
    ST_INRUSH = 3'b100,
    ST_SETTLE = 3'b101
  } guard_state_t;

endpackage

//--- hw/pin_sync.sv
// Three-stage synchroniser for asynchronous pin levels.
// Assumes the pins are slow levels; output follows once stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      meta <= pin;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Accept a bit only when the last two stages agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

//--- hw/tick_timer.sv
// Loadable down-counting delay timer clocked by timebase ticks.
// Assumes tick is a one-cycle pulse; start has priority over stop.
`timescale 1ns/100ps
module tick_timer #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] preset,
  output logic running,
  output logic expired
);

  logic [WIDTH-1:0] count;

  // Presets 0 and 1 both mean one tick; preset N otherwise takes N ticks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count <= preset;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (count <= WIDTH'(1)) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end

endmodule

//--- verification/cold_load_inrush_guard_chk.sv
// Concurrent checks on the cold-load guard's register bus and enable output.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module cold_load_inrush_guard_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic auto_reclose_active,
  input wire logic cold_load_enable
);
  // ****************************************
  // Assertions
  // ****************************************
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before rready");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_reclose_drop: assert property (auto_reclose_active [*3] |-> !cold_load_enable)
    else $error("enable held during auto-reclose");
  chk_reclose_rise: assert property (auto_reclose_active && $past(auto_reclose_active) |->
    !$rose(cold_load_enable)) else $error("enable rose during auto-reclose");
endmodule

bind cold_load_inrush_guard cold_load_inrush_guard_chk cold_load_inrush_guard_chk_i (.*);

//--- verification/feeder_model.sv
// Feeder model: breaker auxiliary contact and current comparator flags.
// Assumes the bench commands the breaker and a load level at clock edges.
`timescale 1ns/100ps
module feeder_model (
  input wire logic ref_clk,
  input wire logic closed_cmd,
  input wire logic [1:0] load_level,
  output logic breaker_position,
  output logic cold_load_undercurrent_flag,
  output logic inrush_above,
  output logic inrush_below_ninety
);
  // Contact follows the command a cycle late, as a real contact never is instant
  always_ff @(posedge ref_clk) begin
    breaker_position <= closed_cmd;
  end

  // Level 0 no load, 1 normal load under 0.9 threshold, 2 inrush above threshold
  always_ff @(posedge ref_clk) begin
    cold_load_undercurrent_flag <= (load_level == 2'h0);
    inrush_above <= (load_level == 2'h2);
    inrush_below_ninety <= (load_level != 2'h2);
  end
endmodule

//--- verification/tb_cold_load_inrush_guard.sv
// Self-checking bench for the cold-load guard with an AXI4-Lite master.
// Assumes a short timebase tick so that delays take a few dozen cycles.
`timescale 1ns/100ps
`include "cold_load_params.svh"
module tb_cold_load_inrush_guard;
  localparam int T = 8;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, ext_block = 0, auto_reclose_active = 0, closed_cmd = 1;
  logic [1:0] load_level = 2'h1, s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic breaker_position, cold_load_undercurrent_flag, inrush_above, inrush_below_ninety;
  logic cold_load_enable, irq;
  logic [7:0] ofs [5] = '{`OFS_CTRL, `OFS_LOADOFF, `OFS_SETTLE, `OFS_MAXBLK, `OFS_IRQ_ENABLE};
  logic [31:0] rst [5] = '{`CTRL_RESET, `LOADOFF_RESET, `SETTLE_RESET, `MAXBLK_RESET,
    `IRQ_ENABLE_RESET};
  int miscompares = 0, tests_run = 0, lf = 3290, nl, n;

  cold_load_inrush_guard #(.TICK_CYCLES(T)) cold_load_inrush_guard_i (.*, .s_axi_wstrb(4'hf));
  feeder_model feeder_model_i (.*);

  // Free-running 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Bus, stimulus and scoring tasks
  // ****************************************
  // Readiness is looked at mid-cycle, where it equals its value at the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge ref_clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge ref_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (!s_axi_arready);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic feed(input logic open, input logic [1:0] lvl);
    @(posedge ref_clk);
    closed_cmd <= !open;
    load_level <= lvl;
  endtask

  // Bounded wait; a miss returns lim, one above every accepted span
  task automatic wait_en(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (cold_load_enable !== v && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_span(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED at %0t: delay %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic int lfsr(input int v);
    return {16'h0000, v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Reference model of cold detection per mode
  function automatic logic cold_of(input int m, input logic open, input logic under);
    case (m)
      0: return open;
      1: return under;
      2: return open && under;
      default: return open || under;
    endcase
  endfunction

  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ofs[i]) begin
      axr(ofs[i], d, r);
      cmp_word(d, rst[i]);
    end
    axr(8'h20, d, r);
    cmp_word(r, 2'b10);
    axw(`OFS_STATUS, 32'hffff, r);
    cmp_word(r, 2'b10);
    axw(`OFS_SETTLE, 32'h3, r);
    axw(`OFS_MAXBLK, 32'hc, r);
    $display("Register defaults done");
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        lf = lfsr(lf);
        nl = 2 + lf % 4;
        axw(`OFS_LOADOFF, nl, r);
        axw(`OFS_CTRL, m | 4, r);
        feed(c[0], c[1] ? 2'h0 : 2'h1);
        wait_en(1'b1, nl * T + 13, n);
        if (cold_of(m, c[0], c[1])) begin
          cmp_span(n, (nl - 1) * T, nl * T + 12);
          feed(1'b0, 2'h1);
          wait_en(1'b0, 3 * T + 17, n);
          cmp_span(n, 2 * T, 3 * T + 16);
        end else begin
          cmp_word(cold_load_enable, 1'b0);
        end
      end
    end
    $display("Detection modes done");
    axw(`OFS_CTRL, 32'h4, r);
    axw(`OFS_IRQ_CLEAR, 32'hf, r);
    axw(`OFS_IRQ_ENABLE, 32'h1, r);
    @(negedge ref_clk);
    cmp_word(irq, 1'b0);
    feed(1'b1, 2'h1);
    wait_en(1'b1, 6 * T + 12, n);
    repeat (3) @(negedge ref_clk);
    cmp_word(irq, 1'b1);
    axw(`OFS_IRQ_ENABLE, 32'h0, r);
    repeat (3) @(negedge ref_clk);
    cmp_word(irq, 1'b0);
    feed(1'b0, 2'h2);
    repeat (5 * T) @(negedge ref_clk);
    cmp_word(cold_load_enable, 1'b1);
    axr(`OFS_IRQ_STATUS, d, r);
    cmp_word(d & 32'h5, 32'h5);
    axw(`OFS_IRQ_CLEAR, 32'h1, r);
    axr(`OFS_IRQ_STATUS, d, r);
    cmp_word(d & 32'h1, 32'h0);
    feed(1'b0, 2'h1);
    wait_en(1'b0, 3 * T + 17, n);
    cmp_span(n, 2 * T, 3 * T + 16);
    $display("Inrush and interrupt done");
    feed(1'b1, 2'h1);
    wait_en(1'b1, 6 * T + 12, n);
    feed(1'b0, 2'h2);
    wait_en(1'b0, 12 * T + 13, n);
    cmp_span(n, 11 * T, 12 * T + 12);
    axr(`OFS_IRQ_STATUS, d, r);
    cmp_word(d[3], 1'b1);
    feed(1'b0, 2'h1);
    $display("Maximum block done");
    for (int k = 0; k < 3; k++) begin
      axw(`OFS_CTRL, 32'hc, r);
      feed(1'b1, 2'h1);
      wait_en(1'b1, 6 * T + 12, n);
      @(posedge ref_clk);
      if (k == 0) axw(`OFS_CTRL, 32'h1c, r);
      ext_block <= (k == 1);
      auto_reclose_active <= (k == 2);
      wait_en(1'b0, 12, n);
      cmp_word(cold_load_enable, 1'b0);
      repeat (7 * T) @(negedge ref_clk);
      cmp_word(cold_load_enable, 1'b0);
      feed(1'b0, 2'h1);
      repeat (8) @(posedge ref_clk);
      ext_block <= 1'b0;
      auto_reclose_active <= 1'b0;
    end
    $display("Blocking done");
    close_out();
  end
endmodule
